/* File: rtl/qaw_pkg.sv */
// Summary of operation
// - Answer bits 7..4: count bit XOR token bits.
// - Answer bits 3..0: token XORs with count bit.
// - Open time at 0xAC, close at 0xAB.
// - Delay code maps to 1/2/4 ms steps.
// - Windows timed within five percent.
// - Watchdog resets never alter window delays.
// - Startup equals (multiplier+1) times window sum.
// - Status reports state codes 0 to 4.
// - Undervolt and expiry flags clear on read.
// - Idle when disabled; idle clears violations.
// - Suspend on fault or manual reset bit.
// - Host selects bank 0, reads question 0x38.
// - Host selects bank 1, writes answer 0xAE.
// - Good answer lowers count; wrong restores three.
// - Close runs full; open answer starts close.
// - Wrong answer: violation up, close restarts.
// - Max violations latch fault; good event decrements.
// - Three close questions, one open; token changes.
package qaw_pkg;
   // ==========================================================
   // Register map
   localparam logic [7:0] ADDR_STATUS = 8'h37;
   localparam logic [7:0] ADDR_QUESTION = 8'h38;
   localparam logic [7:0] ADDR_MULT = 8'hAA;
   localparam logic [7:0] ADDR_CLOSE = 8'hAB;
   localparam logic [7:0] ADDR_OPEN = 8'hAC;
   localparam logic [7:0] ADDR_ANSWER = 8'hAE;
   localparam logic [7:0] ADDR_CFG = 8'hAF;
   localparam logic [7:0] ADDR_BANK = 8'hF0;
   // ==========================================================
   // Reset values
   localparam logic [7:0] RST_MULT = 8'h01;
   localparam logic [7:0] RST_CLOSE = 8'h09;
   localparam logic [7:0] RST_OPEN = 8'h09;
   localparam logic [7:0] RST_CFG = 8'h03;
   localparam logic [1:0] ANS_CNT_START = 2'h3;
   // ==========================================================
   // Field positions of the configuration register
   localparam int CFG_MAXV_LSB = 0;
   localparam int CFG_MR_BIT = 3;
   localparam int CFG_SEL_LSB = 4;
   // ==========================================================
   // State codes as read back
   localparam logic [3:0] CODE_IDLE = 4'h0;
   localparam logic [3:0] CODE_OPEN = 4'h1;
   localparam logic [3:0] CODE_CLOSE = 4'h2;
   localparam logic [3:0] CODE_STARTUP = 4'h3;
   localparam logic [3:0] CODE_SUSPEND = 4'h4;
   // ==========================================================
   // Timing
   localparam int CLK_MHZ = 200;
   localparam int LINK_DIV = 4;
   localparam int MS_US = 1000;
   localparam int LINK_TICKS_PER_MS = MS_US * CLK_MHZ / LINK_DIV;
endpackage

/* File: rtl/qaw_link_if.sv */
`timescale 1ns/1ps
interface qaw_link_if;
   logic link_clk;
   logic req;
   logic we;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic rvalid;
   modport dev (input link_clk, input req, input we, input addr, input wdata,
      output rdata, output rvalid);
   modport host (output link_clk, output req, output we, output addr, output wdata,
      input rdata, input rvalid);
endinterface

/* File: rtl/qaw_answer_calc.sv */
`timescale 1ns/1ps
module qaw_answer_calc (
   input logic [3:0] token,
   input logic [1:0] count,
   input logic [1:0] sel,
   output logic [7:0] answer
);
   // ==========================================================
   // Reference answer per feedback selection
   logic [3:0] t;
   logic c0;
   logic c1;
   assign t = token;
   assign c0 = count[0];
   assign c1 = count[1];
   always_comb begin
      unique case (sel)
         2'h0: begin
            answer[7:4] = {t[2], t[0], t[3], t[1]} ^ {4{c0}};
            answer[3] = t[2] ^ t[0] ^ t[3] ^ c1;
            answer[2] = t[0] ^ t[3] ^ t[1] ^ c1;
            answer[1] = t[0] ^ t[1] ^ t[2] ^ c1;
            answer[0] = t[0] ^ t[3] ^ c1;
         end
         2'h1: begin
            answer[7:4] = {t[1], t[3], t[2], t[0]} ^ {4{c0}};
            answer[3] = t[1] ^ c1;
            answer[2] = t[3] ^ t[2] ^ t[1] ^ c1;
            answer[1] = t[1] ^ c1;
            answer[0] = t[1] ^ t[2] ^ c1;
         end
         2'h2: begin
            answer[7:4] = {t[0], t[2], t[1], t[2]} ^ {4{c0}};
            answer[3] = t[0] ^ t[2] ^ t[3] ^ c1;
            answer[2] = t[1] ^ c1;
            answer[1] = t[2] ^ t[0] ^ t[1] ^ c1;
            answer[0] = t[2] ^ t[1] ^ c1;
         end
         default: begin
            answer[7:4] = {t[3], t[1], t[0], t[3]} ^ {4{c0}};
            answer[3] = t[1] ^ c1;
            answer[2] = t[0] ^ c1;
            answer[1] = t[1] ^ c1;
            answer[0] = t[3] ^ t[0] ^ c1;
         end
      endcase
   end
endmodule

/* File: rtl/qaw_device.sv */
`timescale 1ns/1ps
module qaw_device
   import qaw_pkg::*;
#(
   parameter int unsigned TICKS_PER_MS = LINK_TICKS_PER_MS
) (
   qaw_link_if.dev link,
   input logic srst,
   input logic watchdog_enable_pin,
   input logic unrelated_fault,
   input logic undervolt_event,
   output logic watchdog_fault_out_n,
   output logic [7:0] state_status
);
   // ==========================================================
   // Types and helpers
   typedef enum logic [4:0] {
      ST_IDLE = 5'h01,
      ST_STARTUP = 5'h02,
      ST_CLOSE = 5'h04,
      ST_OPEN = 5'h08,
      ST_SUSPEND = 5'h10
   } qaw_state_t;

   function automatic logic [9:0] code_to_ms(input logic [7:0] c);
      if (c < 8'h20) begin
         code_to_ms = {2'h0, c} + 10'h001;
      end else if (c < 8'h40) begin
         code_to_ms = {1'h0, c, 1'h0} - 10'h01E;
      end else begin
         code_to_ms = {c, 2'h0} - 10'h09C;
      end
   endfunction

   function automatic logic [3:0] state_code(input qaw_state_t s);
      unique case (s)
         ST_OPEN: state_code = CODE_OPEN;
         ST_CLOSE: state_code = CODE_CLOSE;
         ST_STARTUP: state_code = CODE_STARTUP;
         ST_SUSPEND: state_code = CODE_SUSPEND;
         default: state_code = CODE_IDLE;
      endcase
   endfunction

   // ==========================================================
   // Pin synchronisers on the link clock
   // The reset itself is synchronised too, so these flops carry no reset.
   logic [3:0] sync1_reg;
   logic [3:0] sync2_reg;
   logic rst;
   logic en;
   logic flt;
   logic uv;
   always_ff @(posedge link.link_clk) begin
      sync1_reg <= {srst, watchdog_enable_pin, unrelated_fault, undervolt_event};
      sync2_reg <= sync1_reg;
   end
   assign rst = sync2_reg[3];
   assign en = sync2_reg[2];
   assign flt = sync2_reg[1];
   assign uv = sync2_reg[0];

   // ==========================================================
   // Registers and decode
   qaw_state_t st_reg;
   qaw_state_t st_next;
   logic bank_reg;
   logic [7:0] mult_reg;
   logic [7:0] close_reg;
   logic [7:0] open_reg;
   logic [7:0] cfg_reg;
   logic [1:0] cnt_reg;
   logic [1:0] cnt_next;
   logic [3:0] tok_reg;
   logic [3:0] tok_next;
   logic [2:0] viol_reg;
   logic [2:0] viol_next;
   logic wdo_n_reg;
   logic wdo_n_next;
   logic uv_flag_reg;
   logic exp_flag_reg;
   logic exp_set;
   logic [7:0] rdata_reg;
   logic rvalid_reg;
   logic [7:0] status_reg;
   logic [15:0] pre_reg;
   logic [14:0] ms_reg;

   logic wr;
   logic rd;
   logic wr_b1;
   logic rd_status;
   logic ans_wr;
   logic ans_ok;
   logic [7:0] ref_answer;
   logic [7:0] status_val;
   logic [7:0] rd_mux;
   logic [9:0] open_ms;
   logic [9:0] close_ms;
   logic [14:0] startup_ms;
   logic [14:0] target_ms;
   logic pre_wrap;
   logic tmo;
   logic restart;
   logic viol_inc;
   logic [3:0] viol_up;
   logic mr;
   logic [2:0] max_viol;

   assign wr = link.req & link.we;
   assign rd = link.req & ~link.we;
   assign wr_b1 = wr & bank_reg;
   assign rd_status = rd & ~bank_reg & (link.addr == ADDR_STATUS);
   assign ans_wr = wr_b1 & (link.addr == ADDR_ANSWER);
   assign ans_ok = (link.wdata == ref_answer);
   assign mr = cfg_reg[CFG_MR_BIT];
   assign max_viol = cfg_reg[CFG_MAXV_LSB +: 3];
   assign viol_up = {1'h0, viol_reg} + 4'h1;

   qaw_answer_calc u_calc (
      .token(tok_reg),
      .count(cnt_reg),
      .sel(cfg_reg[CFG_SEL_LSB +: 2]),
      .answer(ref_answer)
   );

   assign status_val = {exp_flag_reg, uv_flag_reg, 2'h0, state_code(st_reg)};
   assign rd_mux = (link.addr == ADDR_BANK) ? {7'h00, bank_reg} :
      (~bank_reg && link.addr == ADDR_STATUS) ? status_val :
      (~bank_reg && link.addr == ADDR_QUESTION) ? {2'h0, cnt_reg, tok_reg} :
      (bank_reg && link.addr == ADDR_MULT) ? mult_reg :
      (bank_reg && link.addr == ADDR_CLOSE) ? close_reg :
      (bank_reg && link.addr == ADDR_OPEN) ? open_reg :
      (bank_reg && link.addr == ADDR_CFG) ? cfg_reg : 8'h00;

   // ==========================================================
   // Window timer
   // Whole milliseconds from the link clock, so accuracy is that of the clock.
   assign open_ms = code_to_ms(open_reg);
   assign close_ms = code_to_ms(close_reg);
   assign startup_ms = (15'(mult_reg[2:0]) + 15'h0001) * (15'(open_ms) + 15'(close_ms));
   assign target_ms = (st_reg == ST_STARTUP) ? startup_ms :
      (st_reg == ST_OPEN) ? {5'h00, open_ms} : {5'h00, close_ms};
   assign pre_wrap = (pre_reg == 16'(TICKS_PER_MS - 1));
   assign tmo = pre_wrap & (ms_reg == target_ms - 15'h0001);

   // ==========================================================
   // State machine
   always_comb begin
      st_next = st_reg;
      cnt_next = cnt_reg;
      tok_next = tok_reg;
      viol_next = viol_reg;
      wdo_n_next = wdo_n_reg;
      viol_inc = 1'b0;
      exp_set = 1'b0;
      if (!en) begin
         st_next = ST_IDLE;
         viol_next = 3'h0;
         cnt_next = ANS_CNT_START;
         wdo_n_next = 1'b1;
      end else if (flt || mr) begin
         if (!(st_reg == ST_IDLE && !wdo_n_reg)) begin
            st_next = ST_SUSPEND;
         end
      end else begin
         unique case (st_reg)
            ST_IDLE: begin
               if (wdo_n_reg) begin
                  st_next = ST_STARTUP;
               end
            end
            ST_SUSPEND: st_next = ST_STARTUP;
            ST_STARTUP: begin
               if (tmo) begin
                  st_next = ST_CLOSE;
                  cnt_next = ANS_CNT_START;
               end
            end
            ST_CLOSE: begin
               if (ans_wr) begin
                  if (ans_ok && cnt_reg != 2'h0) begin
                     cnt_next = cnt_reg - 2'h1;
                  end else begin
                     viol_inc = 1'b1;
                  end
               end else if (tmo) begin
                  if (cnt_reg == 2'h0) begin
                     st_next = ST_OPEN;
                  end else begin
                     viol_inc = 1'b1;
                  end
               end
            end
            ST_OPEN: begin
               if (ans_wr && ans_ok) begin
                  st_next = ST_CLOSE;
                  cnt_next = ANS_CNT_START;
                  tok_next = tok_reg + 4'h1;
                  if (viol_reg != 3'h0) begin
                     viol_next = viol_reg - 3'h1;
                  end
               end else if (ans_wr || tmo) begin
                  viol_inc = 1'b1;
               end
            end
            default: st_next = ST_IDLE;
         endcase
         if (viol_inc) begin
            viol_next = viol_up[2:0];
            cnt_next = ANS_CNT_START;
            st_next = ST_CLOSE;
            if (viol_up >= {1'h0, max_viol}) begin
               wdo_n_next = 1'b0;
               exp_set = 1'b1;
               st_next = ST_IDLE;
               viol_next = 3'h0;
            end
         end
      end
   end
   // Restarting on any state change or violation also restarts a CLOSE window.
   assign restart = (st_next != st_reg) | viol_inc;

   // ==========================================================
   // Clocked state
   always_ff @(posedge link.link_clk) begin
      if (rst) begin
         st_reg <= ST_IDLE;
         cnt_reg <= ANS_CNT_START;
         tok_reg <= 4'h0;
         viol_reg <= 3'h0;
         wdo_n_reg <= 1'b1;
         uv_flag_reg <= 1'b0;
         exp_flag_reg <= 1'b0;
         pre_reg <= 16'h0000;
         ms_reg <= 15'h0000;
         rdata_reg <= 8'h00;
         rvalid_reg <= 1'b0;
         status_reg <= 8'h00;
      end else begin
         st_reg <= st_next;
         cnt_reg <= cnt_next;
         tok_reg <= tok_next;
         viol_reg <= viol_next;
         wdo_n_reg <= wdo_n_next;
         uv_flag_reg <= uv | (uv_flag_reg & ~rd_status);
         exp_flag_reg <= exp_set | (exp_flag_reg & ~rd_status);
         pre_reg <= (restart || pre_wrap) ? 16'h0000 : pre_reg + 16'h0001;
         ms_reg <= restart ? 15'h0000 : (pre_wrap ? ms_reg + 15'h0001 : ms_reg);
         rdata_reg <= rd_mux;
         rvalid_reg <= link.req;
         status_reg <= status_val;
      end
   end

   // Only the power-on reset touches the configuration, never a watchdog event.
   always_ff @(posedge link.link_clk) begin
      if (rst) begin
         bank_reg <= 1'b0;
         mult_reg <= RST_MULT;
         close_reg <= RST_CLOSE;
         open_reg <= RST_OPEN;
         cfg_reg <= RST_CFG;
      end else begin
         if (wr && link.addr == ADDR_BANK) begin
            bank_reg <= link.wdata[0];
         end
         if (wr_b1 && link.addr == ADDR_MULT) begin
            mult_reg <= link.wdata;
         end
         if (wr_b1 && link.addr == ADDR_CLOSE) begin
            close_reg <= link.wdata;
         end
         if (wr_b1 && link.addr == ADDR_OPEN) begin
            open_reg <= link.wdata;
         end
         if (wr_b1 && link.addr == ADDR_CFG) begin
            cfg_reg <= link.wdata;
         end
      end
   end

   assign link.rdata = rdata_reg;
   assign link.rvalid = rvalid_reg;
   assign watchdog_fault_out_n = wdo_n_reg;
   assign state_status = status_reg;
endmodule

/* File: rtl/qaw_host.sv */
`timescale 1ns/1ps
module qaw_host
   import qaw_pkg::*;
(
   input logic clk,
   input logic srst,
   qaw_link_if.host link,
   input logic cmd_valid,
   input logic cmd_we,
   input logic [7:0] cmd_addr,
   input logic [7:0] cmd_wdata,
   output logic cmd_ready,
   output logic rsp_valid,
   output logic [7:0] rsp_data,
   input logic answer_go,
   output logic answer_done,
   output logic [7:0] answer_sent
);
   // ==========================================================
   // Link clock divider and transfer engine
   // The link clock is derived here, so link outputs change mid low phase.
   typedef enum logic [1:0] {
      H_IDLE = 2'h1,
      H_WAIT = 2'h2
   } qaw_hstate_t;

   qaw_hstate_t hst_reg;
   logic [1:0] div_reg;
   logic req_reg;
   logic we_reg;
   logic [7:0] addr_reg;
   logic [7:0] wdata_reg;
   logic cmd_ready_reg;
   logic rsp_valid_reg;
   logic [7:0] rsp_data_reg;
   logic answer_done_reg;
   logic [7:0] answer_sent_reg;
   logic seq_reg;
   logic [1:0] step_reg;
   logic [7:0] question_reg;
   logic pend_reg;
   logic p_we_reg;
   logic [7:0] p_addr_reg;
   logic [7:0] p_wdata_reg;

   logic phase0;
   logic accept;
   logic [7:0] calc_answer;
   logic [7:0] seq_addr;
   logic [7:0] seq_wdata;

   assign phase0 = (div_reg == 2'h0);
   assign accept = cmd_ready_reg & (cmd_valid | answer_go);

   qaw_answer_calc u_calc (
      .token(question_reg[3:0]),
      .count(question_reg[5:4]),
      .sel(2'h0),
      .answer(calc_answer)
   );

   assign seq_addr = (step_reg == 2'h1) ? ADDR_QUESTION :
      (step_reg == 2'h3) ? ADDR_ANSWER : ADDR_BANK;
   assign seq_wdata = (step_reg == 2'h3) ? calc_answer :
      ((step_reg == 2'h2) ? 8'h01 : 8'h00);

   always_ff @(posedge clk) begin
      if (srst) begin
         hst_reg <= H_IDLE;
         div_reg <= 2'h0;
         req_reg <= 1'b0;
         we_reg <= 1'b0;
         addr_reg <= 8'h00;
         wdata_reg <= 8'h00;
         cmd_ready_reg <= 1'b0;
         rsp_valid_reg <= 1'b0;
         rsp_data_reg <= 8'h00;
         answer_done_reg <= 1'b0;
         answer_sent_reg <= 8'h00;
         seq_reg <= 1'b0;
         step_reg <= 2'h0;
         question_reg <= 8'h00;
         pend_reg <= 1'b0;
         p_we_reg <= 1'b0;
         p_addr_reg <= 8'h00;
         p_wdata_reg <= 8'h00;
      end else begin
         div_reg <= div_reg + 2'h1;
         cmd_ready_reg <= (hst_reg == H_IDLE) & ~seq_reg & ~pend_reg & ~accept;
         rsp_valid_reg <= 1'b0;
         answer_done_reg <= 1'b0;
         if (accept) begin
            if (answer_go) begin
               seq_reg <= 1'b1;
               step_reg <= 2'h0;
            end else begin
               pend_reg <= 1'b1;
               p_we_reg <= cmd_we;
               p_addr_reg <= cmd_addr;
               p_wdata_reg <= cmd_wdata;
            end
         end
         if (phase0) begin
            unique case (hst_reg)
               H_IDLE: begin
                  if (seq_reg) begin
                     req_reg <= 1'b1;
                     we_reg <= (step_reg != 2'h1);
                     addr_reg <= seq_addr;
                     wdata_reg <= seq_wdata;
                     hst_reg <= H_WAIT;
                     if (step_reg == 2'h3) begin
                        answer_sent_reg <= calc_answer;
                     end
                  end else if (pend_reg) begin
                     req_reg <= 1'b1;
                     we_reg <= p_we_reg;
                     addr_reg <= p_addr_reg;
                     wdata_reg <= p_wdata_reg;
                     pend_reg <= 1'b0;
                     hst_reg <= H_WAIT;
                  end
               end
               H_WAIT: begin
                  if (link.rvalid) begin
                     req_reg <= 1'b0;
                     hst_reg <= H_IDLE;
                     if (seq_reg) begin
                        step_reg <= step_reg + 2'h1;
                        if (step_reg == 2'h1) begin
                           question_reg <= link.rdata;
                        end
                        if (step_reg == 2'h3) begin
                           seq_reg <= 1'b0;
                           answer_done_reg <= 1'b1;
                        end
                     end else begin
                        rsp_valid_reg <= 1'b1;
                        rsp_data_reg <= link.rdata;
                     end
                  end
               end
               default: hst_reg <= H_IDLE;
            endcase
         end
      end
   end

   assign link.link_clk = div_reg[1];
   assign link.req = req_reg;
   assign link.we = we_reg;
   assign link.addr = addr_reg;
   assign link.wdata = wdata_reg;
   assign cmd_ready = cmd_ready_reg;
   assign rsp_valid = rsp_valid_reg;
   assign rsp_data = rsp_data_reg;
   assign answer_done = answer_done_reg;
   assign answer_sent = answer_sent_reg;
endmodule

/* File: tb/qaw_props.sv */
`timescale 1ns/1ps
module qaw_props
   import qaw_pkg::*;
(
   input logic link_clk,
   input logic srst,
   input logic req,
   input logic we,
   input logic [7:0] addr,
   input logic [7:0] wdata,
   input logic [7:0] rdata,
   input logic rvalid
);
   // ==========================================================
   // Shadow of the host's writes.
   // Readback is judged against what crossed the link, not against the device's registers.
   logic bank_reg;
   logic rd_reg;
   logic [7:0] rd_addr_reg;
   logic [7:0] close_reg;
   logic [7:0] open_reg;
   logic [7:0] mult_reg;
   wire wr_hit = req && we;
   wire rd0 = rvalid && rd_reg && !bank_reg;
   wire rd1 = rvalid && rd_reg && bank_reg;
   wire known0 = rd_addr_reg == ADDR_STATUS || rd_addr_reg == ADDR_QUESTION
      || rd_addr_reg == ADDR_BANK;
   always_ff @(posedge link_clk) begin
      rd_reg <= !srst && req && !we;
      rd_addr_reg <= addr;
   end
   always_ff @(posedge link_clk) begin
      if (srst) begin
         bank_reg <= 1'b0;
         close_reg <= RST_CLOSE;
         open_reg <= RST_OPEN;
         mult_reg <= RST_MULT;
      end else if (wr_hit) begin
         if (addr == ADDR_BANK) bank_reg <= wdata[0];
         if (bank_reg && addr == ADDR_CLOSE) close_reg <= wdata;
         if (bank_reg && addr == ADDR_OPEN) open_reg <= wdata;
         if (bank_reg && addr == ADDR_MULT) mult_reg <= wdata;
      end
   end
   // ==========================================================
   // Link checks.
   default clocking cb @(posedge link_clk); endclocking
   default disable iff (srst);
   a_rvalid_follows_req: assert property (req |=> rvalid)
      else $error("read valid missing after request");
   a_rvalid_one_cycle: assert property (rvalid |-> $past(req) ##1 !rvalid)
      else $error("read valid not a single cycle");
   a_req_one_cycle: assert property (req |=> !req)
      else $error("request held too long");
   a_state_code: assert property (rd0 && rd_addr_reg == ADDR_STATUS
      |-> rdata[3:0] <= CODE_SUSPEND && rdata[5:4] == 2'h0)
      else $error("status read gives illegal state");
   a_count_range: assert property (rd0 && rd_addr_reg == ADDR_QUESTION
      |-> rdata[7:6] == 2'h0)
      else $error("question read gives illegal count");
   a_close_readback: assert property (rd1 && rd_addr_reg == ADDR_CLOSE
      |-> rdata == close_reg)
      else $error("close delay readback wrong");
   a_open_readback: assert property (rd1 && rd_addr_reg == ADDR_OPEN
      |-> rdata == open_reg)
      else $error("open delay readback wrong");
   a_mult_readback: assert property (rd1 && rd_addr_reg == ADDR_MULT
      |-> rdata[2:0] == mult_reg[2:0])
      else $error("multiplier readback wrong");
   a_unmapped_zero: assert property (rd0 && !known0 |-> rdata == 8'h00)
      else $error("unmapped read not zero");
endmodule

/* File: tb/testbench.sv */
`timescale 1ns/1ps
module testbench;
   import qaw_pkg::*;
   logic clk, h_srst, d_srst, en, flt, uv, cmd_valid, cmd_we, answer_go;
   logic cmd_ready, rsp_valid, answer_done, fault_n;
   logic [7:0] cmd_addr, cmd_wdata, rsp_data, answer_sent, state_status, q, r;
   int fails, n_tests, t0, dt, cyc;
   qaw_link_if lnk();
   qaw_host u_qaw_host(.clk, .srst(h_srst), .link(lnk), .cmd_valid, .cmd_we, .cmd_addr,
      .cmd_wdata, .cmd_ready, .rsp_valid, .rsp_data, .answer_go, .answer_done, .answer_sent);
   // A short millisecond keeps the open and close windows within a few hundred clocks.
   qaw_device #(.TICKS_PER_MS(10)) u_qaw_device(.link(lnk), .srst(d_srst),
      .watchdog_enable_pin(en), .unrelated_fault(flt), .undervolt_event(uv),
      .watchdog_fault_out_n(fault_n), .state_status);
   qaw_props u_qaw_props(.link_clk(lnk.link_clk), .srst(d_srst), .req(lnk.req),
      .we(lnk.we), .addr(lnk.addr), .wdata(lnk.wdata), .rdata(lnk.rdata),
      .rvalid(lnk.rvalid));
   // ==========================================================
   // Clock and helpers.
   initial begin
      clk = 0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk) cyc <= cyc + 1;
   task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task complete_run;
      $display("Checks %0d, mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   task xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] o);
      int n;
      n = 0;
      do @(posedge clk); while (cmd_ready !== 1'b1);
      cmd_valid <= 1'b1;
      cmd_we <= w;
      cmd_addr <= a;
      cmd_wdata <= d;
      @(posedge clk);
      cmd_valid <= 1'b0;
      do begin
         @(posedge clk);
         n++;
      end while (rsp_valid !== 1'b1 && n < 100);
      if (rsp_valid !== 1'b1) fails++;
      o = rsp_data;
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      xfer(1'b1, a, d, r);
   endtask
   task rd(input logic [7:0] a, output logic [7:0] o);
      xfer(1'b0, a, 8'h00, o);
   endtask
   task ask(output logic [7:0] o);
      wr(ADDR_BANK, 8'h00);
      rd(ADDR_QUESTION, o);
   endtask
   task auto;
      int n;
      n = 0;
      do @(posedge clk); while (cmd_ready !== 1'b1);
      answer_go <= 1'b1;
      @(posedge clk);
      answer_go <= 1'b0;
      do begin
         @(posedge clk);
         n++;
      end while (answer_done !== 1'b1 && n < 200);
      if (answer_done !== 1'b1) fails++;
   endtask
   task wait_st(input logic [3:0] c);
      int n;
      n = 0;
      while (state_status[3:0] !== c && n < 6000) begin
         @(posedge clk);
         n++;
      end
      chk("state", {4'h0, state_status[3:0]}, {4'h0, c});
      dt = cyc - t0;
      t0 = cyc;
   endtask
   task span(input string nm, input int lo, input int hi);
      chk(nm, {7'h00, (dt >= lo && dt <= hi)}, 8'h01);
   endtask
   function automatic logic [7:0] ref_ans(input logic [7:0] s);
      ref_ans[7:4] = {s[2], s[0], s[3], s[1]} ^ {4{s[4]}};
      ref_ans[3] = s[2] ^ s[0] ^ s[3] ^ s[5];
      ref_ans[2] = s[0] ^ s[3] ^ s[1] ^ s[5];
      ref_ans[1] = s[0] ^ s[2] ^ s[1] ^ s[5];
      ref_ans[0] = s[0] ^ s[3] ^ s[5];
   endfunction
   // ==========================================================
   // Sequence.
   initial begin
      {h_srst, d_srst, en} = 3'h7;
      {flt, uv, cmd_valid, cmd_we, answer_go} = 5'h00;
      {cmd_addr, cmd_wdata} = 16'h0000;
      {fails, n_tests, cyc} = 0;
      repeat (5) @(posedge clk);
      h_srst <= 1'b0;
      // The device reset passes a synchroniser, so it outlasts the host's.
      repeat (16) @(posedge clk);
      d_srst <= 1'b0;
      repeat (20) @(posedge clk);
      wr(ADDR_BANK, 8'h01);
      rd(ADDR_MULT, q); chk("mult", q, RST_MULT);
      rd(ADDR_CLOSE, q); chk("close", q, RST_CLOSE);
      wr(ADDR_OPEN, 8'h01);
      wr(ADDR_MULT, 8'h02);
      rd(ADDR_OPEN, q); chk("open", q, 8'h01);
      wr(ADDR_BANK, 8'h00);
      rd(ADDR_STATUS, q); chk("status", q, 8'h03);
      rd(ADDR_MULT, q);
      chk("unmapped", q, 8'h00);
      wait_st(CODE_CLOSE);
      ask(q); chk("count", q & 8'h30, 8'h30);
      auto; chk("answer", answer_sent, ref_ans(q));
      ask(q); chk("count", q & 8'h30, 8'h20);
      wr(ADDR_BANK, 8'h01);
      wr(ADDR_ANSWER, ~ref_ans(q));
      ask(r); chk("count", r & 8'h30, 8'h30);
      auto;
      auto;
      ask(r); chk("count", r & 8'h30, 8'h10);
      auto;
      ask(r);
      chk("count", r & 8'h30, 8'h00);
      wait_st(CODE_OPEN);
      auto;
      repeat (12) @(posedge clk);
      chk("state", {4'h0, state_status[3:0]}, {4'h0, CODE_CLOSE});
      t0 = cyc;
      ask(r); chk("token", r, {2'h0, 2'h3, q[3:0] + 4'h1});
      auto;
      auto;
      auto;
      wait_st(CODE_OPEN);
      // Ten milliseconds of close, less the clocks from the window's start to t0.
      span("close", 370, 410);
      uv <= 1'b1;
      repeat (20) @(posedge clk);
      uv <= 1'b0;
      repeat (20) @(posedge clk);
      wr(ADDR_BANK, 8'h00);
      rd(ADDR_STATUS, q); chk("uvflag", q & 8'h40, 8'h40);
      rd(ADDR_STATUS, q); chk("uvflag", q & 8'h40, 8'h00);
      wr(ADDR_BANK, 8'h01);
      wr(ADDR_CFG, RST_CFG | 8'h08);
      wait_st(CODE_SUSPEND);
      wr(ADDR_CFG, RST_CFG);
      wait_st(CODE_STARTUP);
      wait_st(CODE_CLOSE);
      span("startup", 1368, 1512);
      flt <= 1'b1;
      wait_st(CODE_SUSPEND);
      flt <= 1'b0;
      wait_st(CODE_CLOSE);
      wr(ADDR_BANK, 8'h01);
      wr(ADDR_CFG, 8'h01);
      ask(q);
      wr(ADDR_BANK, 8'h01);
      wr(ADDR_ANSWER, ~ref_ans(q));
      wait_st(CODE_IDLE);
      chk("fault", {7'h00, fault_n}, 8'h00);
      wr(ADDR_BANK, 8'h00);
      rd(ADDR_STATUS, q); chk("expflag", q & 8'h80, 8'h80);
      wr(ADDR_BANK, 8'h01);
      rd(ADDR_OPEN, q); chk("open", q, 8'h01);
      en <= 1'b0;
      repeat (40) @(posedge clk);
      chk("fault", {7'h00, fault_n}, 8'h01);
      en <= 1'b1;
      wait_st(CODE_STARTUP);
      complete_run;
   end
   initial begin
      #300000;
      fails++;
      complete_run;
   end
endmodule
